// ---- rtl/adcsn_pkg.sv ----
// Function
// - interval timer counts slow oscillator ticks on 16 bits, one request every 4 seconds.
// - timer request passes through the event link unit as converter hardware trigger.
// - stop with snooze enable at 1 parks converter in standby awaiting a trigger.
// - trigger in standby enters snooze mode and starts a conversion, cpu stays asleep.
// - conversion finishing in snooze leaves snooze and returns to normal mode.
// - converter samples and converts only analog channel zero.
// - finished conversion writes the result register and pulses conversion end irq.
package adcsn_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int TIMER_WIDTH = 16;
  localparam int SAMPLE_WIDTH = 10;
  localparam int RESULT_WIDTH = 16;
  localparam logic [15:0] TIMER_RELOAD_DEFAULT = 16'hea5f;
  localparam logic [15:0] TIMER_RESET_COUNT = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int SYS_CLK_PERIOD_PS = 4000;
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int CONV_CNT_WIDTH = $clog2(CONV_CYCLES + 1);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCSN_OFF,
    ADCSN_WAIT,
    ADCSN_CONV,
    ADCSN_STANDBY,
    ADCSN_SNOOZE,
    ADCSN_HALT
  } adcsn_state_t;

  typedef struct packed {
    logic converter_enable;
    logic snooze_enable;
    logic link_enable;
    logic timer_start;
    logic stop_exec;
    logic cpu_wake;
  } adcsn_ctrl_t;

  typedef struct packed {
    logic normal_mode;
    logic stop_mode;
    logic standby;
    logic snooze_mode;
    logic converting;
  } adcsn_stat_t;

endpackage

// ---- rtl/adcsn_interval_timer.sv ----
`timescale 1ns/1ps
module adcsn_interval_timer #(
  parameter int WIDTH = adcsn_pkg::TIMER_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic timer_start,
  input wire logic low_speed_osc_clock,
  input wire logic [WIDTH-1:0] reload_value,
  output logic [WIDTH-1:0] count,
  output logic underflow_pulse
);
  import adcsn_pkg::*;

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  // the oscillator arrives as a one-cycle tick in the system clock domain
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic underflow_reg;
  wire at_zero = (count_reg == '0);
  wire tick_underflow = timer_start && low_speed_osc_clock && at_zero;

  // stopped timer holds the reload value so the first period is full length
  assign count_next = !timer_start ? reload_value :
                      !low_speed_osc_clock ? count_reg :
                      at_zero ? reload_value :
                      count_reg - 1'b1;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      count_reg <= WIDTH'(TIMER_RESET_COUNT);
      underflow_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      underflow_reg <= tick_underflow;
    end
  end

  assign count = count_reg;
  assign underflow_pulse = underflow_reg;
endmodule

// ---- rtl/adcsn_top.sv ----
`timescale 1ns/1ps
module adcsn_top #(
  parameter int SAMPLE_W = adcsn_pkg::SAMPLE_WIDTH,
  parameter int CONV_N = adcsn_pkg::CONV_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire adcsn_pkg::adcsn_ctrl_t ctrl,
  input wire logic low_speed_osc_clock,
  input wire logic [adcsn_pkg::TIMER_WIDTH-1:0] reload_value,
  input wire logic [SAMPLE_W-1:0] analog_channel_zero,
  output logic [adcsn_pkg::RESULT_WIDTH-1:0] conversion_result_register,
  output logic conversion_end_irq,
  output logic event_link_pulse,
  output logic cpu_run,
  output adcsn_pkg::adcsn_stat_t status
);
  import adcsn_pkg::*;

  // ----------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------
  logic timer_event;

  adcsn_interval_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .timer_start(ctrl.timer_start),
    .low_speed_osc_clock(low_speed_osc_clock),
    .reload_value(reload_value),
    .count(),
    .underflow_pulse(timer_event)
  );

  // ----------------------------------------------------------------
  // event link unit
  // ----------------------------------------------------------------
  // one register stage; the converter sees the linked event one cycle after underflow
  logic link_reg;
  wire link_next = timer_event && ctrl.link_enable;
  wire hw_trigger = link_reg;

  // ----------------------------------------------------------------
  // converter state
  // ----------------------------------------------------------------
  adcsn_state_t state_reg;
  adcsn_state_t state_next;
  // counter width follows the parameter so a longer conversion cannot wrap it
  localparam int CNT_W = $clog2(CONV_N + 1);
  logic [CNT_W-1:0] conv_cnt_reg;
  logic [CNT_W-1:0] conv_cnt_next;
  logic [SAMPLE_W-1:0] hold_reg;
  logic [SAMPLE_W-1:0] hold_next;
  logic [RESULT_WIDTH-1:0] result_reg;
  logic [RESULT_WIDTH-1:0] result_next;
  logic irq_reg;
  logic cpu_run_reg;
  logic cpu_run_next;
  adcsn_stat_t stat_reg;
  adcsn_stat_t stat_next;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_N - 1);

  wire converting = (state_reg == ADCSN_CONV) || (state_reg == ADCSN_SNOOZE);
  wire conv_done = converting && (conv_cnt_reg == CONV_LAST);
  wire conv_start = ((state_reg == ADCSN_WAIT) || (state_reg == ADCSN_STANDBY)) && hw_trigger;
  // stop entry is only honoured between conversions
  wire stop_req = ctrl.stop_exec && (state_reg == ADCSN_WAIT);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ADCSN_OFF:
      begin
        if (ctrl.converter_enable)
          state_next = ADCSN_WAIT;
      end
      ADCSN_WAIT:
      begin
        if (!ctrl.converter_enable)
          state_next = ADCSN_OFF;
        else if (stop_req && ctrl.snooze_enable)
          state_next = ADCSN_STANDBY;
        else if (stop_req)
          state_next = ADCSN_HALT;
        else if (hw_trigger)
          state_next = ADCSN_CONV;
      end
      ADCSN_CONV:
      begin
        if (conv_done)
          state_next = ADCSN_WAIT;
      end
      ADCSN_STANDBY:
      begin
        if (hw_trigger)
          state_next = ADCSN_SNOOZE;
        else if (ctrl.cpu_wake)
          state_next = ADCSN_WAIT;
      end
      ADCSN_SNOOZE:
      begin
        if (conv_done)
          state_next = ADCSN_WAIT;
      end
      ADCSN_HALT:
      begin
        // without snooze the converter ignores triggers until another source wakes the cpu
        if (ctrl.cpu_wake)
          state_next = ADCSN_WAIT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sampling and result
  // ----------------------------------------------------------------
  assign conv_cnt_next = conv_start ? '0 :
                         (converting && !conv_done) ? conv_cnt_reg + 1'b1 :
                         conv_cnt_reg;
  // only channel zero is wired to the sample and hold
  assign hold_next = conv_start ? analog_channel_zero : hold_reg;
  // result is left aligned, which is why software shifts it down
  assign result_next = conv_done ? {hold_reg, {(RESULT_WIDTH - SAMPLE_W){1'b0}}} : result_reg;

  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  // snooze converts with the cpu still asleep; it runs again once the conversion ends
  assign cpu_run_next = (state_next == ADCSN_OFF) || (state_next == ADCSN_WAIT) ||
                        (state_next == ADCSN_CONV);
  assign stat_next.normal_mode = cpu_run_next;
  assign stat_next.stop_mode = (state_next == ADCSN_STANDBY) || (state_next == ADCSN_HALT);
  assign stat_next.standby = (state_next == ADCSN_STANDBY);
  assign stat_next.snooze_mode = (state_next == ADCSN_SNOOZE);
  assign stat_next.converting = (state_next == ADCSN_CONV) || (state_next == ADCSN_SNOOZE);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      link_reg <= 1'b0;
      state_reg <= ADCSN_OFF;
      conv_cnt_reg <= '0;
      hold_reg <= '0;
      result_reg <= RESULT_RESET;
      irq_reg <= 1'b0;
      cpu_run_reg <= 1'b1;
      stat_reg <= '{normal_mode: 1'b1, default: 1'b0};
    end
    else
    begin
      link_reg <= link_next;
      state_reg <= state_next;
      conv_cnt_reg <= conv_cnt_next;
      hold_reg <= hold_next;
      result_reg <= result_next;
      irq_reg <= conv_done;
      cpu_run_reg <= cpu_run_next;
      stat_reg <= stat_next;
    end
  end

  assign conversion_result_register = result_reg;
  assign conversion_end_irq = irq_reg;
  assign event_link_pulse = link_reg;
  assign cpu_run = cpu_run_reg;
  assign status = stat_reg;
endmodule

// ---- dv/adcsn_top_sva.sv ----
`timescale 1ns/1ps
module adcsn_top_sva #(
  parameter int SAMPLE_W = 10,
  parameter int CONV_N = 250
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire adcsn_pkg::adcsn_ctrl_t ctrl,
  input wire logic low_speed_osc_clock,
  input wire logic [15:0] reload_value,
  input wire logic [SAMPLE_W-1:0] analog_channel_zero,
  input wire logic [15:0] conversion_result_register,
  input wire logic conversion_end_irq,
  input wire logic event_link_pulse,
  input wire logic cpu_run,
  input wire adcsn_pkg::adcsn_stat_t status
);
  import adcsn_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_evt; event_link_pulse |=> !event_link_pulse; endproperty
  a_evt: assert property (p_evt) else $error("event pulse too long");
  property p_link; event_link_pulse |-> $past(ctrl.link_enable); endproperty
  a_link: assert property (p_link) else $error("event passed a closed link");
  // the enable history rules out the off state, where stop is ignored
  property p_stby; ctrl.stop_exec && ctrl.snooze_enable && ctrl.converter_enable && $past(ctrl.converter_enable)
    && status.normal_mode && !status.converting |=> status.standby && !cpu_run; endproperty
  a_stby: assert property (p_stby) else $error("no standby after stop");
  property p_snz; status.standby && event_link_pulse |=> status.snooze_mode && status.converting && !cpu_run; endproperty
  a_snz: assert property (p_snz) else $error("trigger did not start snooze");
  property p_time; $rose(status.converting) |-> ##CONV_N conversion_end_irq; endproperty
  a_time: assert property (p_time) else $error("conversion end late or early");
  property p_irq; conversion_end_irq |=> !conversion_end_irq; endproperty
  a_irq: assert property (p_irq) else $error("end irq too long");
  property p_res; !$stable(conversion_result_register) |-> conversion_end_irq; endproperty
  a_res: assert property (p_res) else $error("result moved without irq");
  property p_norm; conversion_end_irq && $past(status.snooze_mode) |-> cpu_run && status.normal_mode; endproperty
  a_norm: assert property (p_norm) else $error("no return to normal");
  property p_align; conversion_end_irq |-> conversion_result_register[5:0] == 6'h00; endproperty
  a_align: assert property (p_align) else $error("result not left aligned");
  c_snz: cover property (status.standby ##1 status.snooze_mode);
  c_end: cover property (conversion_end_irq && cpu_run);
  c_evt: cover property (event_link_pulse);
endmodule
bind adcsn_top adcsn_top_sva #(.SAMPLE_W(SAMPLE_W), .CONV_N(CONV_N)) u_sva (.sys_clk(sys_clk), .rstn(rstn),
  .ctrl(ctrl), .low_speed_osc_clock(low_speed_osc_clock), .reload_value(reload_value),
  .analog_channel_zero(analog_channel_zero), .conversion_result_register(conversion_result_register),
  .conversion_end_irq(conversion_end_irq), .event_link_pulse(event_link_pulse), .cpu_run(cpu_run), .status(status));

// ---- dv/adcsn_fw_model.sv ----
`timescale 1ns/1ps
module adcsn_fw_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] result,
  input wire logic irq
);
  logic [9:0] ring [10];
  int wr;
  // wake-up handler: oldest entry is overwritten, nothing is ever refused
  always @(posedge sys_clk)
  begin
    if (!rstn)
      wr <= 0;
    else if (irq)
    begin
      ring[wr] <= 10'(result >> 6);
      wr <= (wr == 9) ? 0 : wr + 1;
    end
  end
endmodule

// ---- dv/test_adcsn_top.sv ----
`timescale 1ns/1ps
module test_adcsn_top;
  import adcsn_pkg::*;
  logic sys_clk = 0;
  logic rstn = 0;
  adcsn_ctrl_t ctrl = '0;
  logic tick = 0;
  logic [15:0] reload = 16'h0003; // short period keeps the run brief
  logic [9:0] ain = 10'h000;
  logic [15:0] res;
  logic irq, evt, run;
  adcsn_stat_t st;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  always #2 sys_clk = ~sys_clk;
  adcsn_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .ctrl(ctrl), .low_speed_osc_clock(tick), .reload_value(reload),
    .analog_channel_zero(ain), .conversion_result_register(res), .conversion_end_irq(irq),
    .event_link_pulse(evt), .cpu_run(run), .status(st));
  adcsn_fw_model u_fw (.sys_clk(sys_clk), .rstn(rstn), .result(res), .irq(irq));
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      errors++;
      end_of_test();
    end
  end
  task wait_evt(output int c);
    c = 0;
    do
    begin
      @(negedge sys_clk);
      c++;
    end
    while (evt !== 1'b1 && c < 100);
  endtask
  task t_timer;
    ctrl.timer_start = 1;
    ctrl.link_enable = 1;
    tick = 1;
    wait_evt(n);
    wait_evt(n);
    check("event_gap", 16'(n), reload + 16'h0001);
    ctrl.link_enable = 0;
    wait_evt(n);
    check("event_dropped", 16'(n), 16'h0064);
    tick = 0;
    ctrl.link_enable = 1;
  endtask
  task t_halt;
    ctrl.stop_exec = 1;
    @(negedge sys_clk);
    ctrl.stop_exec = 0;
    tick = 1;
    wait_evt(n);
    tick = 0;
    @(negedge sys_clk);
    check("halt", 16'({run, st.standby, st.converting}), 16'h0000);
    ctrl.cpu_wake = 1;
    @(negedge sys_clk);
    ctrl.cpu_wake = 0;
    @(negedge sys_clk);
    check("halt_wake", 16'(run), 16'h0001);
  endtask
  task t_snooze(input logic [9:0] v);
    ctrl.snooze_enable = 1;
    ctrl.stop_exec = 1;
    @(negedge sys_clk);
    ctrl.stop_exec = 0;
    check("standby", 16'({run, st}), 16'h000c);
    ain = v;
    tick = 1;
    wait_evt(n);
    tick = 0;
    @(negedge sys_clk);
    ain = ~v;
    check("snooze", 16'({run, st}), 16'h0003);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("conv_time", 16'(n), 16'(CONV_CYCLES));
    check("result", res, {v, 6'h00});
    check("wake", 16'({run, st}), 16'h0030);
    ctrl.snooze_enable = 0;
    @(negedge sys_clk);
    check("stored", 16'(u_fw.ring[(u_fw.wr + 9) % 10]), 16'(v));
  endtask
  task t_period;
    reload = TIMER_RELOAD_DEFAULT;
    ain = 10'h2a5;
    ctrl.timer_start = 0;
    @(negedge sys_clk);
    ctrl.timer_start = 1;
    tick = 1;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (evt !== 1'b1 && n < 61000);
    tick = 0;
    // 60000 ticks make 4 s at 15 kHz; one more cycle for the link stage
    check("period", 16'(n), 16'd60001);
    @(negedge sys_clk);
    check("normal_conv", 16'({run, st}), 16'h0031);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("normal_time", 16'(n), 16'(CONV_CYCLES));
    check("normal_result", res, {10'h2a5, 6'h00});
    check("normal_end", 16'({run, st}), 16'h0030);
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk);
    rstn = 1;
    @(negedge sys_clk);
    check("reset", {res[14:0], run}, 16'h0001);
    check("reset_status", 16'(st), 16'h0010);
    t_timer();
    ctrl.converter_enable = 1;
    @(negedge sys_clk);
    t_halt();
    for (int i = 0; i < 11; i++)
      t_snooze(10'(i * 37 + 5));
    check("ring_newest", 16'(u_fw.ring[0]), 16'd375);
    check("ring_oldest", 16'(u_fw.ring[1]), 16'd42);
    t_period();
    end_of_test();
  end
endmodule
